/* hdl/ptc_pkg.sv */
// Purpose: Shared constants and types for the protocol timing register bank.
// Assumes: Registers sit one per 32-bit Wishbone word at byte address four times the index.
// Notes: Data is 16 bits wide in the low half of each word; the upper half reads zero.
package ptc_pkg;

  localparam int PTC_NREG = 9;
  localparam int PTC_DW = 16;
  localparam int PTC_IDX_W = 8;

  // Register indices; byte address is index times four.
  localparam logic [7:0] PTC_IDX_SLOT_COUNT = 8'h8E;
  localparam logic [7:0] PTC_IDX_MACRO_LEN = 8'hAC;
  localparam logic [7:0] PTC_IDX_SLOT_LEN = 8'hB0;
  localparam logic [7:0] PTC_IDX_MPC_LOW = 8'hB4;
  localparam logic [7:0] PTC_IDX_MPC_HIGH = 8'hB6;
  localparam logic [7:0] PTC_IDX_SYNC_LIMIT = 8'hC2;
  localparam logic [7:0] PTC_IDX_DELAY_A = 8'hD0;
  localparam logic [7:0] PTC_IDX_DELAY_B = 8'hD2;
  localparam logic [7:0] PTC_IDX_DRIFT = 8'hDE;
  localparam logic [7:0] PTC_IDX_STATUS = 8'hE0;
  localparam logic [7:0] PTC_IDX_WRITTEN = 8'hE2;
  localparam logic [7:0] PTC_IDX_RANGE = 8'hE4;

  // Positions of the fields in the field arrays below.
  localparam int PTC_F_SLOT_COUNT = 0;
  localparam int PTC_F_MACRO_LEN = 1;
  localparam int PTC_F_SLOT_LEN = 2;
  localparam int PTC_F_MPC_LOW = 3;
  localparam int PTC_F_MPC_HIGH = 4;
  localparam int PTC_F_SYNC_LIMIT = 5;
  localparam int PTC_F_DELAY_A = 6;
  localparam int PTC_F_DELAY_B = 7;
  localparam int PTC_F_DRIFT = 8;

  localparam logic [7:0] PTC_IDX [PTC_NREG] = '{
    PTC_IDX_SLOT_COUNT, PTC_IDX_MACRO_LEN, PTC_IDX_SLOT_LEN, PTC_IDX_MPC_LOW,
    PTC_IDX_MPC_HIGH, PTC_IDX_SYNC_LIMIT, PTC_IDX_DELAY_A, PTC_IDX_DELAY_B, PTC_IDX_DRIFT};
  localparam logic [15:0] PTC_MASK [PTC_NREG] = '{
    16'h07FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam logic PTC_HAS_RST [PTC_NREG] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [15:0] PTC_RST [PTC_NREG] = '{
    16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] PTC_LO [PTC_NREG] = '{
    16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0001};
  localparam logic [15:0] PTC_HI [PTC_NREG] = '{
    16'h03FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'h000F, 16'h007F, 16'h007F, 16'h000F};

  // Status register bit positions.
  localparam int PTC_ST_CONFIG = 0;
  localparam int PTC_ST_REFUSED = 1;
  localparam int PTC_ST_ALL_WRITTEN = 2;
  localparam int PTC_ST_ALL_IN_RANGE = 3;

  typedef struct packed {
    logic [15:0] delay_comp_first_channel;
    logic [15:0] delay_comp_second_channel;
    logic [15:0] drift_damping;
    logic [15:0] sync_frame_limit;
    logic [7:0] nominal_macrotick_length;
    logic [23:0] microticks_per_cycle;
    logic [7:0] static_slot_length;
    logic [10:0] static_slot_count;
  } ptc_cfg_t;

  typedef struct packed {
    logic [PTC_NREG-1:0] written;
    logic [PTC_NREG-1:0] in_range;
  } ptc_health_t;

endpackage

/* hdl/ptc_field.sv */
// Purpose: One configuration field with lane writes, written flag and range check.
// Assumes: Write enables already carry the configuration-state gate.
// Notes: Bits outside MASK are never stored and read as zero.
`timescale 1ns/100ps
`default_nettype none
module ptc_field
#(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic HAS_RST = 1'b0,
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Write side.
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [15:0] wr_data,
  // Field state.
  output logic [15:0] value,
  output logic written,
  output logic in_range
);

  logic [15:0] value_reg;
  logic written_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      value_reg <= RST_VAL & MASK;
    else
    begin
      if (wr_lo)
        value_reg[7:0] <= wr_data[7:0] & MASK[7:0];
      if (wr_hi)
        value_reg[15:8] <= wr_data[15:8] & MASK[15:8];
    end
  end

  // A field without a defined reset counts as unset until software writes it.
  always_ff @(posedge clk)
  begin
    if (rst)
      written_reg <= HAS_RST;
    else if (wr_lo || wr_hi)
      written_reg <= 1'b1;
  end

  assign value = value_reg;
  assign written = written_reg;
  assign in_range = (value_reg >= LO) && (value_reg <= HI);

endmodule
`default_nettype wire

/* hdl/ptc_regs.sv */
// Purpose: Timing and configuration register bank of the bus controller, on classic Wishbone.
// Assumes: CONFIG_STATE is synchronous to CORE_CLK and high while the controller is configured.
// Notes: Every access is answered with ack one cycle after the request is seen.
`timescale 1ns/100ps
`default_nettype none
module ptc_regs
  import ptc_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Wishbone slave.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Controller state.
  input wire logic CONFIG_STATE,
  // Configuration towards the protocol engine.
  output ptc_cfg_t CFG,
  output logic CFG_READY,
  output ptc_health_t HEALTH,
  output logic WRITE_REFUSED
);

  localparam int IW = ADDR_W - 2;

  if (ADDR_W < 10)
  begin : g_addr_check
    $error("ptc_regs: ADDR_W must be at least 10 to reach every register");
  end

  logic access;
  logic wr_access;
  logic [IW-1:0] word_idx;
  logic [PTC_NREG-1:0] hit;
  logic hit_status;
  logic hit_written;
  logic hit_range;
  logic any_field_hit;
  logic [15:0] field_val [PTC_NREG];
  logic [PTC_NREG-1:0] field_written;
  logic [PTC_NREG-1:0] field_in_range;
  logic config_open;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic refused_reg;
  logic refused_set;
  logic refused_clear;
  logic [15:0] status_word;
  ptc_cfg_t cfg_reg;
  ptc_cfg_t cfg_next;
  logic ready_reg;
  ptc_health_t health_reg;

  // A request is seen once; the cycle with ack high is not a second request.
  assign access = WB_CYC_I && WB_STB_I && !ack_reg;
  assign wr_access = access && WB_WE_I;
  assign word_idx = WB_ADR_I[ADDR_W-1:2];

  assign hit_status = (word_idx == IW'(PTC_IDX_STATUS));
  assign hit_written = (word_idx == IW'(PTC_IDX_WRITTEN));
  assign hit_range = (word_idx == IW'(PTC_IDX_RANGE));
  assign any_field_hit = |hit;

  assign config_open = CONFIG_STATE;

  // One storage cell per field; masks drop reserved bits such as the upper byte of
  // the slot length and the top five bits of the slot count.
  for (genvar i = 0; i < PTC_NREG; i++)
  begin : g_field
    assign hit[i] = (word_idx == IW'(PTC_IDX[i]));
    ptc_field
    #(
      .MASK(PTC_MASK[i]),
      .HAS_RST(PTC_HAS_RST[i]),
      .RST_VAL(PTC_RST[i]),
      .LO(PTC_LO[i]),
      .HI(PTC_HI[i])
    )
    u_field
    (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .wr_lo(wr_access && hit[i] && config_open && WB_SEL_I[0]),
      .wr_hi(wr_access && hit[i] && config_open && WB_SEL_I[1]),
      .wr_data(WB_DAT_I[15:0]),
      .value(field_val[i]),
      .written(field_written[i]),
      .in_range(field_in_range[i])
    );
  end

  // A write to a field outside configuration is dropped and remembered here.
  assign refused_set = wr_access && any_field_hit && !config_open;
  assign refused_clear = wr_access && hit_status && WB_SEL_I[0] && WB_DAT_I[PTC_ST_REFUSED];

  // A refusal in the same cycle as the clear keeps the flag set.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      refused_reg <= 1'b0;
    else if (refused_set)
      refused_reg <= 1'b1;
    else if (refused_clear)
      refused_reg <= 1'b0;
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[PTC_ST_CONFIG] = config_open;
    status_word[PTC_ST_REFUSED] = refused_reg;
    status_word[PTC_ST_ALL_WRITTEN] = &field_written;
    status_word[PTC_ST_ALL_IN_RANGE] = &field_in_range;
  end

  // Read data; unmapped words read zero and still get an ack.
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    for (int i = 0; i < PTC_NREG; i++)
    begin
      if (hit[i])
        rdata_next[15:0] = field_val[i];
    end
    if (hit_status)
      rdata_next[15:0] = status_word;
    if (hit_written)
      rdata_next[PTC_NREG-1:0] = field_written;
    if (hit_range)
      rdata_next[PTC_NREG-1:0] = field_in_range;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      ack_reg <= 1'b0;
    else
      ack_reg <= access;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      rdata_reg <= 32'h0000_0000;
    else if (access && !WB_WE_I)
      rdata_reg <= rdata_next;
  end

  // Assemble the values handed to the protocol engine.
  always_comb
  begin
    cfg_next = '0;
    cfg_next.delay_comp_first_channel = field_val[PTC_F_DELAY_A];
    cfg_next.delay_comp_second_channel = field_val[PTC_F_DELAY_B];
    cfg_next.drift_damping = field_val[PTC_F_DRIFT];
    cfg_next.sync_frame_limit = field_val[PTC_F_SYNC_LIMIT];
    cfg_next.nominal_macrotick_length = field_val[PTC_F_MACRO_LEN][7:0];
    cfg_next.microticks_per_cycle =
      {field_val[PTC_F_MPC_HIGH][7:0], field_val[PTC_F_MPC_LOW]};
    cfg_next.static_slot_length = field_val[PTC_F_SLOT_LEN][7:0];
    cfg_next.static_slot_count = field_val[PTC_F_SLOT_COUNT][10:0];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      cfg_reg <= '0;
    else
      cfg_reg <= cfg_next;
  end

  // The engine may use the set only when every field was written and lies in its
  // allowed range; a slot count below two keeps the set from being ready.
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      ready_reg <= 1'b0;
    else
      ready_reg <= (&field_written) && (&field_in_range);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      health_reg <= '0;
    else
    begin
      health_reg.written <= field_written;
      health_reg.in_range <= field_in_range;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;
  assign CFG = cfg_reg;
  assign CFG_READY = ready_reg;
  assign HEALTH = health_reg;
  assign WRITE_REFUSED = refused_reg;

endmodule
`default_nettype wire

/* bench/ptc_regs_checker.sv */
// Purpose: Checks field storage and flags of the timing register bank.
// Assumes: Sees only the top module ports.
// Notes: Bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module ptc_regs_checker
  import ptc_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Bus.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Controller side.
  input wire logic CONFIG_STATE,
  input wire ptc_cfg_t CFG,
  input wire logic CFG_READY,
  input wire ptc_health_t HEALTH,
  input wire logic WRITE_REFUSED
);
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  wire logic tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire logic [7:0] ix = WB_ADR_I[9:2];
  AST_HOLD: assert property (tk && WB_WE_I && !CONFIG_STATE |=> ##1 $stable(CFG))
    else $error("field changed outside configuration state");
  AST_REFUSE: assert property (tk && WB_WE_I && !CONFIG_STATE && (ix inside {PTC_IDX})
    |-> ##[1:2] WRITE_REFUSED) else $error("refused write not flagged");
  AST_SLOT_RST: assert property ($fell(SYS_RST)
    |-> ##1 CFG.static_slot_count == 11'h001 && !CFG_READY) else $error("slot count reset");
  AST_DLY_A: assert property (!$past(SYS_RST)
    |-> HEALTH.in_range[6] == (CFG.delay_comp_first_channel <= 16'h007F)) else $error("range a");
  AST_DLY_B: assert property (!$past(SYS_RST)
    |-> HEALTH.in_range[7] == (CFG.delay_comp_second_channel <= 16'h007F)) else $error("range b");
  AST_DRIFT: assert property (!$past(SYS_RST)
    |-> HEALTH.in_range[8] == (CFG.drift_damping inside {[1:15]})) else $error("drift range");
  AST_SYNC: assert property (!$past(SYS_RST)
    |-> HEALTH.in_range[5] == (CFG.sync_frame_limit inside {[2:15]})) else $error("sync range");
  AST_MPC_LOW: assert property (tk && WB_WE_I && CONFIG_STATE && ix == 8'hB4 && WB_SEL_I[1:0] == 2'h3
    |-> ##2 CFG.microticks_per_cycle[15:0] == $past(WB_DAT_I[15:0], 2)) else $error("low count");
  AST_SLOT_LEN: assert property (WB_ACK_O && !WB_WE_I && ix == 8'hB0
    |-> WB_DAT_O[15:8] == 8'h00) else $error("reserved byte not zero");
endmodule
`default_nettype wire

/* bench/ptc_regs_tb.sv */
// Purpose: Self-checking bench for the timing register bank.
// Assumes: One access at a time over classic Wishbone.
// Notes: Random values from a fixed seed, plus range corners.
`timescale 1ns/100ps
`default_nettype none
module ptc_regs_tb import ptc_pkg::*;;
  logic clk, rst, cyc, stb, we, cs, ack, rdy, refd;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd;
  ptc_cfg_t cfg;
  ptc_health_t hl;
  logic [15:0] q;
  logic [15:0] v [PTC_NREG];
  int err_total, num_checks;
  int cf [8] = '{6, 7, 8, 8, 5, 5, 0, 0};
  logic [15:0] cb [8] = '{16'h0080, 16'h0080, 16'h0000, 16'h0010, 16'h0001, 16'h0010,
    16'h0001, 16'h0400};
  logic [15:0] cg [8] = '{16'h007F, 16'h0000, 16'h000F, 16'h0001, 16'h000F, 16'h0002,
    16'h03FF, 16'h0002};
  ptc_regs #(.ADDR_W(10)) dut (.CORE_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .CONFIG_STATE(cs), .CFG(cfg), .CFG_READY(rdy), .HEALTH(hl), .WRITE_REFUSED(refd));
  always #20 clk = ~clk;
  function automatic logic [15:0] pick(int i, logic [15:0] r);
    case (i)
      0: return r % 16'h03FE + 16'h0002;
      5: return r % 16'h000E + 16'h0002;
      6, 7: return r % 16'h0080;
      8: return r % 16'h000F + 16'h0001;
      default: return r;
    endcase
  endfunction
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One classic cycle; waits for ack, then leaves one idle cycle.
  task automatic wb(input logic w, input logic [7:0] ix, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wd <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      end_of_test();
    end
    q = rd[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    clk = 0;
    rst = 1;
    {cyc, stb, we, cs} = 4'h0;
    adr = 10'h000;
    sel = 4'h3;
    wd = 32'h00000000;
    err_total = 0;
    num_checks = 0;
    void'($urandom(23));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(0, PTC_IDX[0], 16'h0000);
    chk("count reset", q, 16'h0001);
    chk("cfg count reset", cfg.static_slot_count, 11'h001);
    chk("reset written", hl.written, 9'h001);
    cs <= 1'b1;
    for (int i = 0; i < PTC_NREG; i++)
    begin
      if (i == 8)
        chk("early ready", rdy, 1'b0);
      v[i] = pick(i, 16'($urandom));
      wb(1, PTC_IDX[i], v[i]);
    end
    for (int i = 0; i < PTC_NREG; i++)
    begin
      wb(0, PTC_IDX[i], 16'h0000);
      chk("readback", q, v[i] & PTC_MASK[i]);
    end
    chk("cycle count", cfg.microticks_per_cycle, {v[4][7:0], v[3]});
    chk("macro len", cfg.nominal_macrotick_length, v[1][7:0]);
    chk("slot len", cfg.static_slot_length, v[2][7:0]);
    chk("ready", rdy, 1'b1);
    chk("delay a", cfg.delay_comp_first_channel, v[6]);
    chk("delay b", cfg.delay_comp_second_channel, v[7]);
    chk("drift", cfg.drift_damping, v[8]);
    chk("sync limit", cfg.sync_frame_limit, v[5]);
    chk("slot count", cfg.static_slot_count, v[0][10:0]);
    chk("all written", hl.written, 9'h1FF);
    // Only the low lane of the low cycle count may change.
    sel <= 4'h1;
    wb(1, PTC_IDX[3], 16'hA5C3);
    sel <= 4'h3;
    chk("lane write", cfg.microticks_per_cycle[15:0], {v[3][15:8], 8'hC3});
    for (int k = 0; k < 8; k++)
    begin
      wb(1, PTC_IDX[cf[k]], cb[k]);
      chk("range low", hl.in_range[cf[k]], 1'b0);
      wb(1, PTC_IDX[cf[k]], cg[k]);
      chk("range ok", hl.in_range[cf[k]], 1'b1);
    end
    cs <= 1'b0;
    wb(1, PTC_IDX[6], 16'h0055);
    wb(0, PTC_IDX[6], 16'h0000);
    chk("locked", q, 16'h007F);
    chk("refused", refd, 1'b1);
    wb(0, PTC_IDX_STATUS, 16'h0000);
    chk("status", q, 16'h000E);
    wb(1, PTC_IDX_STATUS, 16'h0002);
    chk("refused clear", refd, 1'b0);
    wb(0, PTC_IDX_WRITTEN, 16'h0000);
    chk("written word", q, 16'h01FF);
    wb(0, PTC_IDX_RANGE, 16'h0000);
    chk("range word", q, 16'h01FF);
    wb(0, 8'h10, 16'h0000);
    chk("unmapped", q, 16'h0000);
    end_of_test();
  end
endmodule
bind ptc_regs ptc_regs_checker #(.ADDR_W(ADDR_W)) chk_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CONFIG_STATE(CONFIG_STATE), .CFG(CFG), .CFG_READY(CFG_READY), .HEALTH(HEALTH),
  .WRITE_REFUSED(WRITE_REFUSED));
`default_nettype wire
